// ---- dcam_activity_monitor.sv ----
// top of the dual channel activity monitor: position select, DTR to DCD, activity contacts
// assumes all inputs synchronous to sys_clk; index 0 is channel one, 1 is channel two
`timescale 1ns/1ps
`default_nettype none
`include "dcam_params.svh"

module dcam_activity_monitor
  import dcam_pkg::*;
#(
  parameter int HOLD_CYCLES = `DCAM_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic                                         sys_clk,
  input  wire logic                                         rstn,
  // control contacts and reference, per channel
  input  wire logic [`DCAM_NUM_CH-1:0]                      ctrlContactShort,
  input  wire logic [`DCAM_NUM_CH-1:0]                      actReference,
  // data lines of each port pair, per channel
  input  wire logic [`DCAM_NUM_CH-1:0][`DCAM_NUM_LINES-1:0] sideAPortData,
  input  wire logic [`DCAM_NUM_CH-1:0][`DCAM_NUM_LINES-1:0] sideBPortData,
  // modem lines, per channel
  input  wire logic [`DCAM_NUM_CH-1:0]                      sideAPortDtr,
  input  wire logic [`DCAM_NUM_CH-1:0]                      sideBPortDtr,
  output var  logic [`DCAM_NUM_CH-1:0]                      sideAPortDcd,
  output var  logic [`DCAM_NUM_CH-1:0]                      sideBPortDcd,
  // switch position, high for position B
  output var  logic [`DCAM_NUM_CH-1:0]                      posIsB,
  // activity contacts and the level they pass
  output var  logic [`DCAM_NUM_CH-1:0]                      sideAActClosed,
  output var  logic [`DCAM_NUM_CH-1:0]                      sideBActClosed,
  output var  logic [`DCAM_NUM_CH-1:0]                      sideAActLevel,
  output var  logic [`DCAM_NUM_CH-1:0]                      sideBActLevel
);

  // -----------------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------------
  function automatic logic anyEdge(input logic [`DCAM_NUM_LINES-1:0] cur,
                                   input logic [`DCAM_NUM_LINES-1:0] prev);
    anyEdge = |(cur ^ prev);
  endfunction

  dcam_top_state_t                                   q, d;
  logic [`DCAM_NUM_PAIRS-1:0][`DCAM_NUM_LINES-1:0]   pairData;
  logic [`DCAM_NUM_PAIRS-1:0]                        pairEdge;
  logic [`DCAM_NUM_PAIRS-1:0]                        holdActive;

  // -----------------------------------------------------------------------------
  // per pair activity detection and hold
  // -----------------------------------------------------------------------------
  // one detector per pair
  for (genvar c = 0; c < `DCAM_NUM_CH; c++) begin : g_map
    assign pairData[c*2+`DCAM_SIDE_A] = sideAPortData[c];
    assign pairData[c*2+`DCAM_SIDE_B] = sideBPortData[c];
  end

  for (genvar p = 0; p < `DCAM_NUM_PAIRS; p++) begin : g_pair
    assign pairEdge[p] = anyEdge(pairData[p], q.prevData[p]);

    dcam_hold_timer #(
      .HOLD_CYCLES (HOLD_CYCLES)
    ) u_timer (
      .sys_clk  (sys_clk),
      .rstn     (rstn),
      .edgeSeen (pairEdge[p]),
      .active   (holdActive[p])
    );
  end

  // -----------------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------------
  always_comb begin
    d          = q;
    d.prevData = pairData;
    for (int c = 0; c < `DCAM_NUM_CH; c++) begin
      // open selects A, short selects B
      // position is re-read every cycle, so it aligns right after reset
      d.pos[c] = ctrlContactShort[c] ? DCAM_POS_B : DCAM_POS_A;
      // side A DTR to DCD in position A
      d.dcdA[c] = (q.pos[c] == DCAM_POS_A) && sideAPortDtr[c];
      // side B DTR to DCD in position B
      d.dcdB[c] = (q.pos[c] == DCAM_POS_B) && sideBPortDtr[c];
    end
    for (int p = 0; p < `DCAM_NUM_PAIRS; p++) begin
      // contact follows the hold timer, which runs one second past the last edge
      d.actClosed[p] = holdActive[p];
      // pass the channel reference only while closed
      d.actLevel[p]  = holdActive[p] && actReference[p/2];
    end
  end

  // the position flops hold A while rstn is low; the contact is taken at the first clock after release
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q.pos       <= '{default: DCAM_POS_A};
      q.dcdA      <= '0;
      q.dcdB      <= '0;
      q.actClosed <= '0;
      q.actLevel  <= '0;
      q.prevData  <= '0;
    end else begin
      q <= d;
    end
  end

  // -----------------------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------------------
  // every output is a flop, valid each cycle without request
  for (genvar c = 0; c < `DCAM_NUM_CH; c++) begin : g_out
    assign posIsB[c]         = (q.pos[c] == DCAM_POS_B);
    assign sideAPortDcd[c]   = q.dcdA[c];
    assign sideBPortDcd[c]   = q.dcdB[c];
    assign sideAActClosed[c] = q.actClosed[c*2+`DCAM_SIDE_A];
    assign sideBActClosed[c] = q.actClosed[c*2+`DCAM_SIDE_B];
    assign sideAActLevel[c]  = q.actLevel[c*2+`DCAM_SIDE_A];
    assign sideBActLevel[c]  = q.actLevel[c*2+`DCAM_SIDE_B];
  end

  // -----------------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // -----------------------------------------------------------------------------
  // activity checks
  // -----------------------------------------------------------------------------
  // sampled rstn gates the antecedents: an edge seen while the flops sit in reset loads nothing
  for (genvar p = 0; p < `DCAM_NUM_PAIRS; p++) begin : g_chk
    property p_edgeCloses;
      rstn && pairEdge[p] |-> ##2 q.actClosed[p];
    endproperty
    a_edgeCloses: assert property (p_edgeCloses) else $error("activity contact did not close");

    property p_level;
      q.actLevel[p] == ($past(actReference[p/2]) && q.actClosed[p]);
    endproperty
    a_level: assert property (p_level) else $error("activity level wrong");

    property p_release;
      $fell(holdActive[p]) |-> q.actClosed[p] ##1 !q.actClosed[p];
    endproperty
    a_release: assert property (p_release) else $error("activity contact release timing");

    property p_indep;
      !holdActive[p] |=> !q.actClosed[p];
    endproperty
    a_indep: assert property (p_indep) else $error("contact closed without own activity");

    property p_openLevel;
      !q.actClosed[p] |-> !q.actLevel[p];
    endproperty
    a_openLevel: assert property (p_openLevel) else $error("open contact passes reference");

    property p_loadNext;
      rstn && pairEdge[p] |=> holdActive[p];
    endproperty
    a_loadNext: assert property (p_loadNext) else $error("transition did not start hold timer");
  end

  // -----------------------------------------------------------------------------
  // position and modem checks
  // -----------------------------------------------------------------------------
  for (genvar c = 0; c < `DCAM_NUM_CH; c++) begin : g_chkCh
    property p_pos;
      (rstn && ctrlContactShort[c]) [*2] |-> posIsB[c] ##1 posIsB[c];
    endproperty
    a_pos: assert property (p_pos) else $error("position does not follow contact");

    property p_posA;
      (rstn && !ctrlContactShort[c]) [*2] |-> !posIsB[c] ##1 !posIsB[c];
    endproperty
    a_posA: assert property (p_posA) else $error("position does not return to A");

    property p_powerUp;
      $rose(rstn) |=> posIsB[c] == $past(ctrlContactShort[c]);
    endproperty
    a_powerUp: assert property (p_powerUp) else $error("position not aligned after reset");

    property p_dcdA;
      ##1 sideAPortDcd[c] == ($past(rstn) && !$past(posIsB[c]) && $past(sideAPortDtr[c]));
    endproperty
    a_dcdA: assert property (p_dcdA) else $error("side A DCD wrong");

    property p_dcdB;
      ##1 sideBPortDcd[c] == ($past(rstn) && $past(posIsB[c]) && $past(sideBPortDtr[c]));
    endproperty
    a_dcdB: assert property (p_dcdB) else $error("side B DCD wrong");

    property p_refuseA;
      posIsB[c] |=> !sideAPortDcd[c];
    endproperty
    a_refuseA: assert property (p_refuseA) else $error("side A DCD driven in position B");

    property p_refuseB;
      !posIsB[c] |=> !sideBPortDcd[c];
    endproperty
    a_refuseB: assert property (p_refuseB) else $error("side B DCD driven in position A");

    property p_dtrLowA;
      !sideAPortDtr[c] |=> !sideAPortDcd[c];
    endproperty
    a_dtrLowA: assert property (p_dtrLowA) else $error("side A DCD without DTR");

    property p_dtrLowB;
      !sideBPortDtr[c] |=> !sideBPortDcd[c];
    endproperty
    a_dtrLowB: assert property (p_dtrLowB) else $error("side B DCD without DTR");
  end

  // -----------------------------------------------------------------------------
  // coverage
  // -----------------------------------------------------------------------------
  // the reference-off case shows a closed contact that passes nothing
  c_refOff: cover property (sideAActClosed[1] && !sideAActLevel[1]);
  c_closeA1: cover property (pairEdge[0] ##2 sideAActClosed[0]);
  c_releaseB2: cover property ($fell(sideBActClosed[1]));
  c_toB: cover property (!posIsB[0] ##1 posIsB[0]);
  c_dcdB: cover property (sideBPortDcd[1]);

endmodule
`default_nettype wire

// ---- dcam_params.svh ----
// constants of the dual channel activity monitor: timing, indexing, reset values
// assumes a 200 MHz sys_clk and inputs already synchronous to it
//
// Contract
// - each port pair of each channel has its own independent activity indication
// - channel one side A activity connects channel one reference to its side A output
// - channel one side B activity connects channel one reference to its side B output
// - channel two side A activity connects channel two reference to its side A output
// - channel two side B activity connects channel two reference to its side B output
// - after activity stops the output stays asserted one more second, then releases
// - in position A the side A input DTR is forwarded to side A DCD
// - in position B the side B input DTR is forwarded to side B DCD
// - activity outputs are always valid, no request or handshake needed
// - control contact open selects position A, shorted selects position B
// - after power up position follows the control contact, nothing is remembered
`ifndef DCAM_PARAMS_SVH
`define DCAM_PARAMS_SVH

// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define DCAM_CLK_KHZ        200000
`define DCAM_HOLD_TIME_MS   1000
`define DCAM_HOLD_CYCLES    (`DCAM_HOLD_TIME_MS * `DCAM_CLK_KHZ)
`define DCAM_CNT_W          28

// -----------------------------------------------------------------------------
// indexing: pair = channel * 2 + side
// -----------------------------------------------------------------------------
`define DCAM_NUM_CH         2
`define DCAM_NUM_PAIRS      4
`define DCAM_NUM_LINES      2
`define DCAM_SIDE_A         0
`define DCAM_SIDE_B         1

// -----------------------------------------------------------------------------
// reset values
// -----------------------------------------------------------------------------
`define DCAM_RST_CNT        28'h0000000
`define DCAM_RST_BIT        1'b0

`endif

// ---- dcam_pkg.sv ----
// types of the dual channel activity monitor
// assumes dcam_params.svh is on the include path
`default_nettype none
`include "dcam_params.svh"

package dcam_pkg;

  typedef enum logic {
    DCAM_POS_A,
    DCAM_POS_B
  } dcam_pos_t;

  typedef struct packed {
    logic [`DCAM_CNT_W-1:0] cnt;
    logic                   active;
  } dcam_timer_state_t;

  typedef struct packed {
    dcam_pos_t [`DCAM_NUM_CH-1:0]                          pos;
    logic      [`DCAM_NUM_CH-1:0]                          dcdA;
    logic      [`DCAM_NUM_CH-1:0]                          dcdB;
    logic      [`DCAM_NUM_PAIRS-1:0]                       actClosed;
    logic      [`DCAM_NUM_PAIRS-1:0]                       actLevel;
    logic      [`DCAM_NUM_PAIRS-1:0][`DCAM_NUM_LINES-1:0] prevData;
  } dcam_top_state_t;

endpackage
`default_nettype wire

// ---- dcam_hold_timer.sv ----
// retriggerable hold timer for one port pair
// assumes edgeSeen is a one-cycle pulse synchronous to sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "dcam_params.svh"

module dcam_hold_timer
  import dcam_pkg::*;
#(
  parameter int HOLD_CYCLES = `DCAM_HOLD_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // activity
  input  wire logic edgeSeen,
  output var  logic active
);

  dcam_timer_state_t q, d;

  // -----------------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------------
  always_comb begin
    d = q;
    if (edgeSeen) begin
      d.cnt = `DCAM_CNT_W'(HOLD_CYCLES);
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
    end
    d.active = (d.cnt != '0);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q.cnt    <= `DCAM_RST_CNT;
      q.active <= `DCAM_RST_BIT;
    end else begin
      q <= d;
    end
  end

  assign active = q.active;

  // -----------------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  property p_reload;
    rstn && edgeSeen |=> active && q.cnt == `DCAM_CNT_W'(HOLD_CYCLES);
  endproperty
  a_reload: assert property (p_reload) else $error("hold timer not reloaded");

  property p_expire;
    !edgeSeen && q.cnt == `DCAM_CNT_W'(1) |=> !active;
  endproperty
  a_expire: assert property (p_expire) else $error("hold timer did not expire");

  property p_hold;
    active && !edgeSeen && q.cnt > `DCAM_CNT_W'(1) |=> active && q.cnt == $past(q.cnt) - 1'b1;
  endproperty
  a_hold: assert property (p_hold) else $error("hold timer dropped early");

endmodule
`default_nettype wire

// ---- dcam_remote_monitor.sv ----
// model of the remote monitoring equipment: drives the activity references, reads the contacts
// assumes contact levels settle after each rising sys_clk edge; samples them on the falling edge
`timescale 1ns/1ps
`default_nettype none

module dcam_remote_monitor (
  // clock
  input  wire logic       sys_clk,
  // command from the bench
  input  wire logic [1:0] refEnable,
  // reference out, contact levels in
  output var  logic [1:0] actReference,
  input  wire logic [1:0] sideAActLevel,
  input  wire logic [1:0] sideBActLevel,
  // pair p = channel * 2 + side
  output var  logic [3:0] seenActive
);
  // ---------------------------------------------------------------------------
  // reference drive
  // ---------------------------------------------------------------------------
  // reference per channel
  // a withdrawn reference is modelled as a dead line, so the contacts can only pass 0
  always_comb actReference = refEnable;

  // ---------------------------------------------------------------------------
  // contact sampling
  // ---------------------------------------------------------------------------
  // sampled without handshake
  always_ff @(negedge sys_clk) seenActive <= {sideBActLevel[1], sideAActLevel[1], sideBActLevel[0], sideAActLevel[0]};
endmodule

`default_nettype wire

// ---- tb_dual_channel_activity_monitor.sv ----
// testbench of the dual channel activity monitor with a remote monitoring model
// assumes a short hold count; drives inputs on rising edges, looks after falling edges
`timescale 1ns/1ps
`default_nettype none

module tb_dual_channel_activity_monitor;
  // ---------------------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------------------
  localparam int H = 12;
  logic            sys_clk, rstn;
  logic [1:0]      ctrlContactShort, actReference, refEnable, sideAPortDtr, sideBPortDtr;
  logic [1:0][1:0] sideAPortData, sideBPortData;
  logic [1:0]      sideAPortDcd, sideBPortDcd, posIsB;
  logic [1:0]      sideAActClosed, sideBActClosed, sideAActLevel, sideBActLevel;
  logic [3:0]      seenActive, acts;
  int              fails, checked;
  assign acts = {sideBActClosed[1], sideAActClosed[1], sideBActClosed[0], sideAActClosed[0]};

  dcam_activity_monitor #(.HOLD_CYCLES(H)) uut (
    .sys_clk(sys_clk), .rstn(rstn), .ctrlContactShort(ctrlContactShort), .actReference(actReference),
    .sideAPortData(sideAPortData), .sideBPortData(sideBPortData), .sideAPortDtr(sideAPortDtr),
    .sideBPortDtr(sideBPortDtr), .sideAPortDcd(sideAPortDcd), .sideBPortDcd(sideBPortDcd), .posIsB(posIsB),
    .sideAActClosed(sideAActClosed), .sideBActClosed(sideBActClosed), .sideAActLevel(sideAActLevel),
    .sideBActLevel(sideBActLevel));

  dcam_remote_monitor mon (
    .sys_clk(sys_clk), .refEnable(refEnable), .actReference(actReference),
    .sideAActLevel(sideAActLevel), .sideBActLevel(sideBActLevel), .seenActive(seenActive));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // n rising edges, then look after the falling edge so the model has sampled too
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
    #1;
  endtask

  task automatic toggle(input int p, input logic [1:0] v);
    @(posedge sys_clk);
    if (p % 2 == 1) sideBPortData[p/2] <= sideBPortData[p/2] ^ v;
    else sideAPortData[p/2] <= sideAPortData[p/2] ^ v;
  endtask

  task automatic wrap_up();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    @(posedge sys_clk);
    ctrlContactShort <= 2'h3;
    rstn             <= 1'b0;
    tick(1);
    chk(posIsB, 2'h0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    tick(1);
    chk(posIsB, 2'h3);
    chk(acts, 4'h0);
  endtask

  task automatic t_pos_dcd();
    logic [3:0] v;
    for (int i = 0; i < 16; i++) begin
      v = i[3:0];
      @(posedge sys_clk);
      ctrlContactShort <= v[1:0];
      sideAPortDtr     <= v[3:2];
      sideBPortDtr     <= ~v[3:2];
      tick(3);
      chk(posIsB, v[1:0]);
      chk(sideAPortDcd, v[3:2] & ~v[1:0]);
      chk(sideBPortDcd, ~v[3:2] & v[1:0]);
    end
  endtask

  // one pair active alone, retriggered midway, then released after the hold
  task automatic t_activity(input int p);
    logic [3:0] m;
    m = 4'h1 << p;
    toggle(p, 2'h1);
    tick(2);
    chk(acts, m);
    chk(seenActive, m);
    tick(4);
    toggle(p, 2'h2);
    tick(H + 1);
    chk(acts, m);
    tick(1);
    chk(acts, 4'h0);
    chk(seenActive, 4'h0);
  endtask

  task automatic t_ref_off();
    toggle(2, 2'h3);
    refEnable <= 2'h1;
    tick(3);
    chk(acts, 4'h4);
    chk(seenActive, 4'h0);
    @(posedge sys_clk);
    refEnable <= 2'h3;
    tick(2);
    chk(seenActive, 4'h4);
    tick(H + 2);
    chk(acts, 4'h0);
  endtask

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    fails++;
    wrap_up();
  end

  initial begin
    fails            = 0;
    checked          = 0;
    rstn             = 1'b0;
    ctrlContactShort = 2'h0;
    refEnable        = 2'h3;
    sideAPortDtr     = 2'h0;
    sideBPortDtr     = 2'h0;
    sideAPortData    = '0;
    sideBPortData    = '0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_pos_dcd();
    for (int p = 0; p < 4; p++) t_activity(p);
    t_ref_off();
    wrap_up();
  end
endmodule

`default_nettype wire
